/* File: hw/hbsc_top.sv */
/*
 * Host bus strap configuration: captures straps at reset release,
 * selects the host bus mode, decodes register selection and drives
 * the shared host pins per mode.
 * Assumes straps are stable while reset is high and that host strobes
 * come from outside the mclk_i domain.
 */
`timescale 1ns/1ns

// What this block does
// - Capture six strap lines at reset fall
// - Weak internal pull-ups on strap lines
// - Top strap bits select ISA, MCA, local
// - Memory kind flag reported, no behaviour effect
// - Strap bit zero picks I/O map
// - Local mode ignores map, uses select lines
// - Any low bus strap means external config
// - All-high bus straps load all-ones default
// - ISA/MCA drive buffer direction and enable
// - ISA/MCA decode I/O address internally
// - Local mode uses plain data bus
// - DMA offered per mode, none on MCA
// - Standard register cycles on ISA/MCA
// - Shared pins follow selected bus mode
// - Select codes zero to four pick registers
module hbsc_top (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic [5:0]            fb_data_lines_i,
    output logic      [5:0]            fb_pullup_en_o,
    output logic      [15:0]           config_setup_o,
    output hbsc_pkg::hbsc_bus_t        bus_mode_o,
    output logic                       ext_config_o,
    output logic                       memory_kind_flag_o,
    input  wire logic [15:0]           io_addr_i,
    input  wire logic                  io_cycle_i,
    input  wire logic                  chip_select_n_i,
    input  wire logic [2:0]            reg_select_lines_i,
    input  wire logic                  io_read_n_i,
    output logic                       reg_hit_o,
    output logic      [2:0]            reg_index_o,
    output logic                       addr_mux_en_o,
    output logic                       dma_direct_o,
    output logic                       dma_indexed_o,
    output logic                       pin43_o,
    output logic                       pin43_oe_n_o,
    output logic                       pin44_o,
    output logic                       pin44_oe_n_o,
    input  wire logic                  burst_final_n_i
);
    import hbsc_pkg::*;

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    logic [15:0] cfg_r;      // Configuration setup register
    logic [15:0] cfg_nxt;    // Next value
    logic        armed_r;    // High until capture done
    logic        armed_nxt;  // Next value
    logic [5:0]  strap_s0_r; // Strap synchroniser, first stage
    logic [5:0]  strap_s1_r; // Second stage
    logic [5:0]  strap_s2_r; // Third stage, the one captured
    logic        strap_agree; // Last two stages show one pattern

    // Weak pull-ups kept on always; straps are inputs only here
    assign fb_pullup_en_o = STRAP_DEFLT;

    // Strap synchroniser. No reset on purpose: it keeps sampling while
    // reset is high, so at release its last stages hold reset levels
    // and later frame-buffer traffic cannot reach the capture.
    always_ff @(posedge mclk_i) begin
        strap_s0_r <= fb_data_lines_i;
        strap_s1_r <= strap_s0_r;
        strap_s2_r <= strap_s1_r;
    end
    assign strap_agree = (strap_s1_r == strap_s2_r);

    // Capture once after reset release, when the last two stages
    // agree, then freeze until the next reset. The capture lands one
    // clock after release since mclk_i is the only clock in here.
    always_comb begin
        cfg_nxt   = cfg_r;
        armed_nxt = armed_r;
        if (armed_r && strap_agree) begin
            armed_nxt = 1'b0;
            if (&strap_s2_r[HBS_HI:HBS_LO]) begin
                // All bus straps high: fixed all-ones default
                cfg_nxt = {10'h000, STRAP_DEFLT};
            end else begin
                // External pattern; the reserved bit reads zero
                cfg_nxt    = {10'h000, strap_s2_r};
                cfg_nxt[2] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_r   <= CFG_RESET;
            armed_r <= 1'b1;
        end else begin
            cfg_r   <= cfg_nxt;
            armed_r <= armed_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    logic [2:0] hbs;
    logic       is_local;
    logic       is_mca;
    assign hbs = cfg_r[HBS_HI:HBS_LO];
    assign is_local = (hbs == HBS_LOCAL);
    assign is_mca   = (hbs == HBS_MCA);

    always_comb begin
        if (is_local) begin
            bus_mode_o = BUS_LOCAL;
        end else if (is_mca) begin
            bus_mode_o = BUS_MCA;
        end else begin
            bus_mode_o = BUS_ISA;
        end
    end

    assign config_setup_o     = cfg_r;
    assign ext_config_o       = ~is_local;
    // Flag only; nothing else reads it
    assign memory_kind_flag_o = cfg_r[MKF_BIT];

    // ------------------------------------------------------------------
    // Host input synchronisers (three stages, agree on last two)
    // ------------------------------------------------------------------
    logic [2:0] cs_sync_r;   // Chip select, three stages
    logic [2:0] rd_sync_r;   // I/O read, three stages
    logic [2:0] rs_s0_r;     // Register select, first stage
    logic [2:0] rs_s1_r;     // Register select, second stage
    logic [2:0] rs_s2_r;     // Register select, third stage
    logic       cs_lvl_r;    // Accepted chip select level, low active
    logic       cs_lvl_nxt;  // Next value
    logic       rd_lvl_r;    // Accepted read strobe level, low active
    logic       rd_lvl_nxt;  // Next value
    logic [2:0] rs_lvl_r;    // Accepted register select code
    logic [2:0] rs_lvl_nxt;  // Next value
    logic       cs_act;      // Chip select asserted
    logic       rd_act;      // Read strobe asserted

    // Stages reset to the idle level of each pin, so that no false
    // strobe follows reset
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_sync_r <= 3'h7;
            rd_sync_r <= 3'h7;
            rs_s0_r   <= 3'h0;
            rs_s1_r   <= 3'h0;
            rs_s2_r   <= 3'h0;
        end else begin
            cs_sync_r <= {cs_sync_r[1:0], chip_select_n_i};
            rd_sync_r <= {rd_sync_r[1:0], io_read_n_i};
            rs_s0_r   <= reg_select_lines_i;
            rs_s1_r   <= rs_s0_r;
            rs_s2_r   <= rs_s1_r;
        end
    end

    // A new level counts only once the second and third stages agree;
    // a glitch seen by one stage alone is dropped here
    always_comb begin
        cs_lvl_nxt = cs_lvl_r;
        rd_lvl_nxt = rd_lvl_r;
        rs_lvl_nxt = rs_lvl_r;
        if (cs_sync_r[1] == cs_sync_r[2]) begin
            cs_lvl_nxt = cs_sync_r[2];
        end
        if (rd_sync_r[1] == rd_sync_r[2]) begin
            rd_lvl_nxt = rd_sync_r[2];
        end
        if (rs_s1_r == rs_s2_r) begin
            rs_lvl_nxt = rs_s2_r;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_lvl_r <= 1'b1;
            rd_lvl_r <= 1'b1;
            rs_lvl_r <= 3'h0;
        end else begin
            cs_lvl_r <= cs_lvl_nxt;
            rd_lvl_r <= rd_lvl_nxt;
            rs_lvl_r <= rs_lvl_nxt;
        end
    end
    assign cs_act = ~cs_lvl_r;
    assign rd_act = ~rd_lvl_r;

    // ------------------------------------------------------------------
    // Register selection
    // ------------------------------------------------------------------
    logic [15:0] io_base;
    logic [15:0] io_off;
    logic        hit_nxt;
    logic [2:0]  idx_nxt;
    logic        hit_r;
    logic [2:0]  idx_r;
    // Map choice used only off local mode
    assign io_base = cfg_r[PMS_BIT] ? IO_SECONDARY : IO_PRIMARY;
    assign io_off  = io_addr_i - io_base;

    always_comb begin
        hit_nxt = 1'b0;
        idx_nxt = 3'h0;
        if (is_local) begin
            // Only select lines address registers
            if (cs_act && (rs_lvl_r <= RSEL_MAX)) begin
                hit_nxt = 1'b1;
                idx_nxt = rs_lvl_r;
            end
        end else if (io_cycle_i && !io_off[0] &&
                     (io_off[15:1] <= {12'h000, RSEL_MAX})) begin
            hit_nxt = 1'b1;
            idx_nxt = io_off[3:1];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hit_r <= 1'b0;
            idx_r <= 3'h0;
        end else begin
            hit_r <= hit_nxt;
            idx_r <= idx_nxt;
        end
    end
    assign reg_hit_o   = hit_r;
    assign reg_index_o = idx_r;

    // ------------------------------------------------------------------
    // Shared pin behaviour
    // ------------------------------------------------------------------
    // Address/data muxing only off local mode
    assign addr_mux_en_o = ~is_local;
    assign dma_direct_o  = (bus_mode_o == BUS_ISA);
    assign dma_indexed_o = is_local;

    // Pin 43: direction output in ISA/MCA, input in local
    assign pin43_o      = is_local ? 1'b0 : rd_act;
    assign pin43_oe_n_o = is_local;
    // Pin 44: buffer enable low during hit, select input in local
    assign pin44_o      = is_local ? 1'b0 : ~hit_r;
    assign pin44_oe_n_o = is_local;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Configuration holds still once the capture is done
    chk_cfg_frozen: assert property (@(posedge mclk_i)
        disable iff (rst_i) !armed_r |=> $stable(cfg_r))
        else $error("configuration changed after capture");
    // Local mode only comes from the all-ones default
    chk_default_ones: assert property (@(posedge mclk_i)
        disable iff (rst_i) is_local |-> cfg_r[5:0] == STRAP_DEFLT)
        else $error("local mode without all-ones default");
    // Shared pin 43 is an input in local mode only
    chk_pin_dir: assert property (@(posedge mclk_i)
        disable iff (rst_i) pin43_oe_n_o == is_local)
        else $error("pin 43 direction does not follow mode");
    // Local hits never name a register beyond the fifth
    chk_local_sel: assert property (@(posedge mclk_i)
        disable iff (rst_i) is_local && hit_r |-> idx_r <= RSEL_MAX)
        else $error("local hit with out-of-range select");
    // No DMA port at all on the MCA bus
    chk_mca_dma: assert property (@(posedge mclk_i)
        disable iff (rst_i) is_mca |-> !dma_direct_o && !dma_indexed_o)
        else $error("DMA offered in MCA mode");
    // External configuration whenever a bus strap was low
    chk_ext_cfg: assert property (@(posedge mclk_i)
        disable iff (rst_i) ext_config_o == !(&cfg_r[5:3]))
        else $error("external configuration flag wrong");
    // Data buffer enabled while an own register is hit
    chk_enable_hit: assert property (@(posedge mclk_i)
        disable iff (rst_i) !is_local && hit_r |-> !pin44_o)
        else $error("buffer enable not low on a hit");
    // External straps land in the register, reserved bit cleared
    chk_strap_take: assert property (@(posedge mclk_i)
        disable iff (rst_i) armed_r && strap_agree && !(&strap_s2_r[5:3])
        |=> cfg_r[5:0] == {$past(strap_s2_r[5:3]), 1'b0,
        $past(strap_s2_r[1:0])}) else $error("strap pattern not captured");
    // A selected local register is hit on the next clock
    chk_local_pick: assert property (@(posedge mclk_i)
        disable iff (rst_i) is_local && cs_act && (rs_lvl_r <= RSEL_MAX)
        |=> hit_r && (idx_r == $past(rs_lvl_r)))
        else $error("local register select not honoured");
    // Without chip select local mode hits nothing, map ignored
    chk_local_idle: assert property (@(posedge mclk_i)
        disable iff (rst_i) is_local && !cs_act |=> !hit_r)
        else $error("local hit without chip select");
    // Offset four above the chosen map base is the index register
    chk_map_pick: assert property (@(posedge mclk_i)
        disable iff (rst_i) !is_local && io_cycle_i &&
        (io_addr_i == io_base + 16'h0004) |=> hit_r && (idx_r == 3'h2))
        else $error("own I/O address not decoded");
    // The map that was not chosen stays silent
    chk_map_other: assert property (@(posedge mclk_i)
        disable iff (rst_i) !is_local && io_cycle_i && (io_addr_i ==
        ((cfg_r[PMS_BIT] ? IO_PRIMARY : IO_SECONDARY) + 16'h0004))
        |=> !hit_r) else $error("unselected I/O map decoded");
    // ISA offers the direct memory port only
    chk_isa_dma: assert property (@(posedge mclk_i)
        disable iff (rst_i) bus_mode_o == BUS_ISA
        |-> dma_direct_o && !dma_indexed_o) else $error("ISA DMA port wrong");
    // Local mode: indexed port and a plain, unmultiplexed data bus
    chk_local_bus: assert property (@(posedge mclk_i)
        disable iff (rst_i) is_local
        |-> dma_indexed_o && !dma_direct_o && !addr_mux_en_o)
        else $error("local bus set-up wrong");
    // Buffer points toward the host during an accepted read
    chk_dir_read: assert property (@(posedge mclk_i)
        disable iff (rst_i) !is_local && rd_act |-> pin43_o)
        else $error("buffer direction not set for read");
    // Strap pull-ups stay enabled at all times
    chk_pullups_on: assert property (@(posedge mclk_i)
        disable iff (rst_i) fb_pullup_en_o == STRAP_DEFLT)
        else $error("strap pull-ups disabled");
    // Memory kind flag is the captured bit and nothing else
    chk_kind_flag: assert property (@(posedge mclk_i)
        disable iff (rst_i) memory_kind_flag_o == cfg_r[MKF_BIT])
        else $error("memory kind flag differs from capture");
endmodule // hbsc_top

/* File: hw/hbsc_pkg.sv */
/*
 * Package for the host bus strap configuration block: field positions,
 * mode codes, register select codes and I/O address map constants.
 * Assumes the user includes it before the design module.
 */
package hbsc_pkg;
    // ------------------------------------------------------------------
    // Field positions inside the configuration setup register
    // ------------------------------------------------------------------
    localparam int unsigned CFG_W        = 16;
    localparam int unsigned STRAP_W      = 6;
    localparam int unsigned PMS_BIT      = 0;   // Port map select
    localparam int unsigned MKF_BIT      = 1;   // Memory kind flag
    localparam int unsigned HBS_LO       = 3;   // Host bus select low bit
    localparam int unsigned HBS_HI       = 5;   // Host bus select high bit
    localparam logic [15:0] CFG_RESET    = 16'h0000;
    localparam logic [5:0]  STRAP_DEFLT  = 6'h3F;
    // ------------------------------------------------------------------
    // Host bus select codes (ISA/MCA codes are a plain choice)
    // ------------------------------------------------------------------
    localparam logic [2:0]  HBS_ISA      = 3'h0;
    localparam logic [2:0]  HBS_MCA      = 3'h1;
    localparam logic [2:0]  HBS_LOCAL    = 3'h7;
    typedef enum logic [1:0] {
        BUS_ISA,
        BUS_MCA,
        BUS_LOCAL
    } hbsc_bus_t;
    // ------------------------------------------------------------------
    // Register select codes and I/O maps
    // ------------------------------------------------------------------
    localparam logic [2:0]  RSEL_MAX     = 3'h4;
    localparam logic [15:0] IO_PRIMARY   = 16'h27C0;
    localparam logic [15:0] IO_SECONDARY = 16'h0290;
endpackage : hbsc_pkg

/* File: verif/hbsc_board_model.sv */
/* Board-side model: strap buffer and frame-buffer line traffic.
   Assumes one mclk_i domain and an active-high reset. */
`timescale 1ns/1ns
module hbsc_board_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       ext_i,    // Board fits a strap buffer
    input  wire logic [5:0] strap_i,  // Pattern behind the buffer
    input  wire logic       busy_i,   // Frame-buffer traffic after reset
    input  wire logic [5:0] pullup_i, // Pull-up enables from the device
    output logic      [5:0] lines_o
);
    logic       hold_r; // Buffer enable lags reset by one clock
    logic [5:0] cnt_r;  // Traffic pattern, 6'h15 in reset, then changes every cycle
    // ------------------------------------------------------------
    // Buffer enable and traffic
    // ------------------------------------------------------------
    // Stretched so the pattern is still valid at the capture edge
    always_ff @(posedge mclk_i) begin
        hold_r <= rst_i;
        cnt_r  <= rst_i ? 6'h15 : cnt_r + 6'h01;
    end
    // Released lines float to the pulled-up level, never the old one
    always_comb begin
        if (ext_i && (rst_i || hold_r)) begin
            lines_o = strap_i;
        end else if (busy_i) begin
            lines_o = cnt_r;
        end else begin
            lines_o = pullup_i | ~strap_i;
        end
    end
endmodule // hbsc_board_model

/* File: verif/host_bus_strap_config_tb_top.sv */
/* Self-checking bench for hbsc_top with a board model.
   Assumes hbsc_pkg is compiled first. */
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module host_bus_strap_config_tb_top;
    import hbsc_pkg::*;
    logic mclk_i = 0, rst_i = 1, io_cycle_i = 0, cs_n = 1, rd_n = 1;
    logic ext = 0, busy = 0, hit, m43, oe43, oe44, mux, dd, di, ec, mk;
    logic [5:0] strap = 6'h00, lines, pu;
    logic [15:0] io_addr_i = 16'h0000, cfg;
    logic [2:0] rs = 3'h0, idx;
    logic p44;
    hbsc_bus_t mode;
    int fail_count = 0, checks = 0;
    // One host clock also stands in for the processor clock
    initial forever #20 mclk_i = ~mclk_i;
    hbsc_board_model u_board (.mclk_i(mclk_i), .rst_i(rst_i), .ext_i(ext),
        .strap_i(strap), .busy_i(busy), .pullup_i(pu), .lines_o(lines));
    hbsc_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .fb_data_lines_i(lines),
        .fb_pullup_en_o(pu), .config_setup_o(cfg), .bus_mode_o(mode),
        .ext_config_o(ec), .memory_kind_flag_o(mk), .io_addr_i(io_addr_i),
        .io_cycle_i(io_cycle_i), .chip_select_n_i(cs_n),
        .reg_select_lines_i(rs), .io_read_n_i(rd_n), .reg_hit_o(hit),
        .reg_index_o(idx), .addr_mux_en_o(mux), .dma_direct_o(dd),
        .dma_indexed_o(di), .pin43_o(m43), .pin43_oe_n_o(oe43),
        .pin44_o(p44), .pin44_oe_n_o(oe44), .burst_final_n_i(1'b1));
    // Reset with a given strap set-up, held 4 clocks
    task automatic do_reset(input logic e, input logic [5:0] s);
        @(negedge mclk_i);
        rst_i = 1'b1;
        ext = e;
        strap = s;
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask
    // One I/O cycle; hit is registered one clock later
    task automatic io_hit(input logic [15:0] a, input logic h,
                          input logic [2:0] i, input logic loc);
        io_addr_i = a;
        io_cycle_i = 1'b1;
        @(negedge mclk_i);
        `CHK(hit, h)
        if (h) `CHK(idx, i)
        if (loc) `CHK(oe44, 1'b1)
        else `CHK(p44, ~h)
        io_cycle_i = 1'b0;
        @(negedge mclk_i);
    endtask
    task automatic t_isa;
        do_reset(1'b1, 6'h07);
        `CHK(cfg, 16'h0003)
        `CHK({mode, ec, mk}, {BUS_ISA, 2'b11})
        `CHK({mux, dd, di, oe43, oe44}, 5'b11000)
        io_hit(16'h0294, 1'b1, 3'h2, 1'b0);
        io_hit(16'h27C4, 1'b0, 3'h0, 1'b0);
        rd_n = 1'b0;
        repeat (5) @(negedge mclk_i);
        `CHK(m43, 1'b1)
        rd_n = 1'b1;
    endtask
    task automatic t_mca;
        do_reset(1'b1, 6'h08);
        `CHK({cfg, mode, mk}, {16'h0008, BUS_MCA, 1'b0})
        `CHK({mux, dd, di}, 3'b100)
        io_hit(16'h27C8, 1'b1, 3'h4, 1'b0);
        io_hit(16'h0298, 1'b0, 3'h0, 1'b0);
        busy = 1'b1;
        repeat (8) @(negedge mclk_i);
        `CHK(cfg, 16'h0008)
        busy = 1'b0;
    endtask
    task automatic t_local;
        do_reset(1'b1, 6'h38);
        `CHK(cfg, 16'h003F)
        do_reset(1'b0, 6'h00);
        `CHK({cfg, mode, ec}, {16'h003F, BUS_LOCAL, 1'b0})
        `CHK({mux, dd, di, oe43, oe44}, 5'b00111)
        `CHK(pu, 6'h3F)
        io_hit(16'h0290, 1'b0, 3'h0, 1'b1);
        cs_n = 1'b0;
        for (int i = 0; i < 6; i++) begin
            rs = 3'(i);
            repeat (5) @(negedge mclk_i);
            `CHK(hit, (i <= 4))
            if (i <= 4) `CHK(idx, 3'(i))
        end
        cs_n = 1'b1;
    endtask
    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog: the whole run needs well under 2500 clocks
    initial begin
        #100000;
        fail_count++;
        final_report;
    end
    initial begin
        t_isa;
        t_mca;
        t_local;
        final_report;
    end
endmodule // host_bus_strap_config_tb_top
